// ---- rtl/grh_param_bank.sv ----
// Holder of the motion parameters taken in by a handshake
`timescale 1ns/1ps
module grh_param_bank (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Load strobe and values from the host
  input wire logic i_load,
  input wire logic [15:0] i_part_window,
  input wire logic [15:0] i_clamp_force,
  input wire logic [15:0] i_travel_speed,
  input wire logic [15:0] i_outer_jaw_target,
  input wire logic [15:0] i_switchover_point,
  input wire logic [15:0] i_expected_part_position,
  input wire logic [15:0] i_inner_jaw_target,
  // Stored values
  output logic [15:0] o_part_window,
  output logic [15:0] o_clamp_force,
  output logic [15:0] o_travel_speed,
  output logic [15:0] o_outer_jaw_target,
  output logic [15:0] o_switchover_point,
  output logic [15:0] o_expected_part_position,
  output logic [15:0] o_inner_jaw_target
);
  import grh_pkg::*;

  typedef struct packed {
    logic [6:0][15:0] word;
  } grh_bank_t;

  grh_bank_t bank_reg;
  grh_bank_t bank_next;

  always_comb begin
    bank_next = bank_reg;
    if (i_load) begin
      bank_next.word = {i_part_window, i_clamp_force, i_travel_speed, i_outer_jaw_target,
                        i_switchover_point, i_expected_part_position, i_inner_jaw_target};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      bank_reg <= '{word: {7{PARAM_RESET}}};
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign {o_part_window, o_clamp_force, o_travel_speed, o_outer_jaw_target,
          o_switchover_point, o_expected_part_position, o_inner_jaw_target} = bank_reg.word;
endmodule

// ---- rtl/grh_pkg.sv ----
// Constants, types and helpers of the gripper command handshake block
package grh_pkg;
  // ------------------------------------------------------------
  // Process data codes
  // ------------------------------------------------------------
  localparam logic [15:0] CMD_IDLE = 16'h0000;
  localparam logic [15:0] CMD_TRANSFER = 16'h0001;
  localparam logic [15:0] CMD_TO_OUTER = 16'h0100;
  localparam logic [15:0] CMD_TO_INNER = 16'h0200;
  localparam logic [7:0] PROF_MOTOR_ON = 8'h03;
  localparam logic [7:0] PROF_MOTOR_OFF = 8'h05;
  localparam logic [7:0] PROF_INSIDE_PREPOS = 8'h5c;
  localparam logic [7:0] RECIPE_LIVE = 8'h00;
  localparam logic [7:0] PROF_RESET = 8'h00;
  // ------------------------------------------------------------
  // State word bits and fault codes
  // ------------------------------------------------------------
  localparam int SW_DRIVE_POWERED = 1;
  localparam int SW_HOST_LINK = 6;
  localparam int SW_FLAGS_LSB = 8;
  localparam int SW_ACK = 12;
  localparam int FL_OUTER = 0;
  localparam int FL_PART = 1;
  localparam int FL_INNER = 2;
  localparam int FL_NONE = 3;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_BOOTING = 16'h0100;
  localparam logic [15:0] FAULT_BAD_CMD = 16'h0002;
  localparam logic [15:0] ARRIVE_TOL = 16'h0005;
  localparam logic [15:0] ILIM_POSITION = 16'hffff;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_MASK = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam logic [3:0] REG_STATE = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0400_0001;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int IRQ_ACK = 0;
  localparam int IRQ_ARRIVED = 1;
  localparam int IRQ_CONTACT = 2;
  localparam int IRQ_BAD_CMD = 3;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_PREPOS = 3'h1,
    M_FORCE = 3'h3,
    M_HOLD = 3'h2,
    M_STOPPED = 3'h7,
    M_OPEN = 3'h4,
    M_OPENED = 3'h5
  } grh_motion_t;

  function automatic logic grh_near(input logic [15:0] a, input logic [15:0] b,
                                    input logic [15:0] tol);
    logic [15:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= tol;
  endfunction
endpackage

// ---- rtl/grh_pos_flags.sv ----
// Arrival flags of the jaws against the stored targets
`timescale 1ns/1ps
module grh_pos_flags (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Position and targets
  input wire logic [15:0] i_jaw_position,
  input wire logic [15:0] i_outer_jaw_target,
  input wire logic [15:0] i_expected_part_position,
  input wire logic [15:0] i_inner_jaw_target,
  input wire logic [15:0] i_part_window,
  // Flags: outer, part, inner, none
  output logic [3:0] o_flags
);
  import grh_pkg::*;

  typedef struct packed {
    logic [3:0] flags;
  } grh_flags_t;

  grh_flags_t fl_reg;
  grh_flags_t fl_next;
  logic [2:0] hit;
  logic [2:0][15:0] tgt;
  logic [2:0][15:0] tol;

  assign tgt = {i_inner_jaw_target, i_expected_part_position, i_outer_jaw_target};
  assign tol = {ARRIVE_TOL, i_part_window, ARRIVE_TOL};

  for (genvar g = 0; g < 3; g++) begin : g_hit
    assign hit[g] = grh_near(i_jaw_position, tgt[g], tol[g]);
  end

  always_comb begin
    fl_next.flags = {~|hit, hit};
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      fl_reg <= '{flags: 4'h8};
    end else begin
      fl_reg <= fl_next;
    end
  end

  assign o_flags = fl_reg.flags;

  property p_none_flag;
    @(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> (o_flags[FL_NONE] == !(|o_flags[2:0]));
  endproperty
  a_none_flag: assert property (p_none_flag) else $error("none flag wrong");
endmodule

// ---- rtl/grh_top.sv ----
// Command and state word interpreter of the gripper process data link
`timescale 1ns/1ps
module grh_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Host process data
  input wire logic [15:0] i_command_word,
  input wire logic [7:0] i_profile_select,
  input wire logic [7:0] i_recipe_index,
  input wire logic [15:0] i_part_window,
  input wire logic [15:0] i_clamp_force,
  input wire logic [15:0] i_travel_speed,
  input wire logic [15:0] i_outer_jaw_target,
  input wire logic [15:0] i_switchover_point,
  input wire logic [15:0] i_expected_part_position,
  input wire logic [15:0] i_inner_jaw_target,
  // Device answers
  output logic [15:0] o_state_word,
  output logic [15:0] o_fault_code,
  output logic [15:0] o_jaw_position_now,
  // Drive side
  input wire logic i_boot_done,
  input wire logic [15:0] i_jaw_position,
  input wire logic [15:0] i_motor_current,
  output logic o_drive_enable,
  output logic o_drive_force_mode,
  output logic o_drive_dir,
  output logic [15:0] o_drive_target,
  output logic [15:0] o_drive_speed,
  output logic [15:0] o_current_limit,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);
  import grh_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic booted;
    logic ack;
    logic drive_powered;
    logic [7:0] prof;
    grh_motion_t motion;
    logic [15:0] state_word;
    logic [15:0] fault;
    logic [15:0] jaw;
    logic drive_en;
    logic force_mode;
    logic dir;
    logic [15:0] target;
    logic [15:0] speed;
    logic [15:0] ilimit;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic irq;
  } grh_state_t;

  grh_state_t st_reg;
  grh_state_t st_next;

  logic [15:0] p_window, p_force, p_speed, p_outer, p_switch, p_expected, p_inner;
  logic [3:0] flags;
  logic cmd_ok, link_up, accept, load_params, run_ok, contact, at_switch;
  logic [3:0] events;

  // ------------------------------------------------------------
  // Parameter store and arrival flags
  // ------------------------------------------------------------
  grh_param_bank u_bank (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_load(load_params),
    .i_part_window(i_part_window),
    .i_clamp_force(i_clamp_force),
    .i_travel_speed(i_travel_speed),
    .i_outer_jaw_target(i_outer_jaw_target),
    .i_switchover_point(i_switchover_point),
    .i_expected_part_position(i_expected_part_position),
    .i_inner_jaw_target(i_inner_jaw_target),
    .o_part_window(p_window),
    .o_clamp_force(p_force),
    .o_travel_speed(p_speed),
    .o_outer_jaw_target(p_outer),
    .o_switchover_point(p_switch),
    .o_expected_part_position(p_expected),
    .o_inner_jaw_target(p_inner)
  );

  grh_pos_flags u_flags (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_jaw_position(i_jaw_position),
    .i_outer_jaw_target(p_outer),
    .i_expected_part_position(p_expected),
    .i_inner_jaw_target(p_inner),
    .i_part_window(p_window),
    .o_flags(flags)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign cmd_ok = $countones(i_command_word) <= 1;
  assign link_up = st_reg.booted & st_reg.ctrl[0];
  assign accept = link_up & (i_command_word == CMD_TRANSFER) & ~st_reg.ack;
  assign load_params = accept & (i_recipe_index == RECIPE_LIVE);
  assign run_ok = st_reg.drive_powered & ~st_reg.ack & link_up &
                  (st_reg.prof == PROF_INSIDE_PREPOS);
  assign contact = i_motor_current > st_reg.ctrl[31:16];
  assign at_switch = grh_near(i_jaw_position, p_switch, ARRIVE_TOL);

  always_comb begin
    st_next = st_reg;
    if (i_boot_done) begin
      st_next.booted = 1'b1;
    end
    // Handshake
    if (accept) begin
      st_next.ack = 1'b1;
      st_next.prof = i_profile_select;
      if (i_profile_select == PROF_MOTOR_ON) begin
        st_next.drive_powered = 1'b1;
      end else if (i_profile_select == PROF_MOTOR_OFF) begin
        st_next.drive_powered = 1'b0;
      end
    end else if (st_reg.ack && i_command_word == CMD_IDLE) begin
      st_next.ack = 1'b0;
    end
    // Motion sequencer
    if (accept || !run_ok) begin
      st_next.motion = M_IDLE;
    end else if (cmd_ok) begin
      unique case (st_reg.motion)
        M_IDLE: begin
          if (i_command_word == CMD_TO_INNER) begin
            st_next.motion = M_OPEN;
          end else if (i_command_word == CMD_TO_OUTER) begin
            st_next.motion = M_PREPOS;
          end
        end
        M_OPEN: begin
          if (i_command_word != CMD_TO_INNER) begin
            st_next.motion = M_IDLE;
          end else if (flags[FL_INNER]) begin
            st_next.motion = M_OPENED;
          end
        end
        M_OPENED: begin
          if (i_command_word != CMD_TO_INNER) begin
            st_next.motion = M_IDLE;
          end
        end
        M_PREPOS: begin
          if (i_command_word != CMD_TO_OUTER) begin
            st_next.motion = M_IDLE;
          end else if (at_switch) begin
            st_next.motion = M_FORCE;
          end
        end
        M_FORCE: begin
          if (i_command_word != CMD_TO_OUTER) begin
            st_next.motion = M_IDLE;
          end else if (contact) begin
            st_next.motion = M_HOLD;
          end else if (flags[FL_OUTER]) begin
            st_next.motion = M_STOPPED;
          end
        end
        M_HOLD, M_STOPPED: begin
          if (i_command_word != CMD_TO_OUTER) begin
            st_next.motion = M_IDLE;
          end
        end
        default: st_next.motion = M_IDLE;
      endcase
    end
    // Drive commands follow the next motion state
    st_next.drive_en = st_next.motion inside {M_OPEN, M_PREPOS, M_FORCE, M_HOLD};
    st_next.force_mode = st_next.motion inside {M_FORCE, M_HOLD};
    st_next.speed = (st_next.motion == M_HOLD) ? 16'h0000 : p_speed;
    st_next.ilimit = st_next.force_mode ? p_force : ILIM_POSITION;
    st_next.target = (st_next.motion == M_OPEN) ? p_inner :
                     (st_next.motion == M_PREPOS) ? p_switch : p_outer;
    if (!st_next.drive_en) begin
      st_next.speed = 16'h0000;
    end
    st_next.dir = st_next.target > i_jaw_position;
    // Reporting starts once booted
    st_next.state_word = 16'h0000;
    st_next.jaw = 16'h0000;
    st_next.fault = FAULT_BOOTING;
    if (st_next.booted) begin
      st_next.state_word[SW_DRIVE_POWERED] = st_next.drive_powered;
      st_next.state_word[SW_HOST_LINK] = st_next.ctrl[0];
      st_next.state_word[SW_FLAGS_LSB +: 4] = flags;
      st_next.state_word[SW_ACK] = st_next.ack;
      st_next.jaw = i_jaw_position;
      st_next.fault = cmd_ok ? FAULT_NONE : FAULT_BAD_CMD;
    end
    // Register port
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        REG_IRQ_MASK: st_next.irq_mask = i_reg_wdata[3:0];
        REG_CONTROL: st_next.ctrl = i_reg_wdata;
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_IRQ_STATUS: st_next.rdata = {28'h0000000, st_reg.irq_status};
        REG_IRQ_MASK: st_next.rdata = {28'h0000000, st_reg.irq_mask};
        REG_CONTROL: st_next.rdata = st_reg.ctrl;
        REG_STATE: st_next.rdata = {16'h0000, st_reg.state_word};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    events = 4'h0;
    events[IRQ_ACK] = accept;
    events[IRQ_ARRIVED] = (st_next.motion != st_reg.motion) &&
                          (st_next.motion inside {M_OPENED, M_STOPPED});
    events[IRQ_CONTACT] = (st_next.motion == M_HOLD) && (st_reg.motion != M_HOLD);
    events[IRQ_BAD_CMD] = st_reg.booted & ~cmd_ok;
    // Sticky events; a read clears, a same-cycle event wins
    if (i_reg_rd && i_reg_addr == REG_IRQ_STATUS) begin
      st_next.irq_status = 4'h0;
    end
    st_next.irq_status = st_next.irq_status | events;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '{motion: M_IDLE, fault: FAULT_BOOTING, ctrl: CTRL_RESET,
                  irq_mask: MASK_RESET, prof: PROF_RESET, ilimit: ILIM_POSITION,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_state_word = st_reg.state_word;
  assign o_fault_code = st_reg.fault;
  assign o_jaw_position_now = st_reg.jaw;
  assign o_drive_enable = st_reg.drive_en;
  assign o_drive_force_mode = st_reg.force_mode;
  assign o_drive_dir = st_reg.dir;
  assign o_drive_target = st_reg.target;
  assign o_drive_speed = st_reg.speed;
  assign o_current_limit = st_reg.ilimit;
  assign o_reg_rdata = st_reg.rdata;
  assign o_irq = st_reg.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb_chk @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_prepos_then_force;
    (st_reg.motion == M_PREPOS) ##1 (st_reg.motion == M_FORCE);
  endsequence
  property p_ack_set;
    accept |=> o_state_word[SW_ACK] ##1 (o_state_word[SW_ACK] || i_command_word == CMD_IDLE);
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("ack not set");
  property p_ack_clear;
    (st_reg.ack && i_command_word == CMD_IDLE) |=> !o_state_word[SW_ACK];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack not cleared");
  property p_motor_on;
    (accept && i_profile_select == PROF_MOTOR_ON) |=>
      (o_state_word[SW_DRIVE_POWERED] && o_state_word[SW_ACK]);
  endproperty
  a_motor_on: assert property (p_motor_on) else $error("motor on missing");
  property p_motor_off;
    (accept && i_profile_select == PROF_MOTOR_OFF) |=>
      (!o_state_word[SW_DRIVE_POWERED] && o_state_word[SW_ACK] && !o_drive_enable);
  endproperty
  a_motor_off: assert property (p_motor_off) else $error("motor off missing");
  property p_bad_cmd;
    (!cmd_ok && !accept && run_ok) |=> $stable(st_reg.motion);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("invalid command acted on");
  property p_cancel;
    accept |=> (st_reg.motion == M_IDLE && !o_drive_enable);
  endproperty
  a_cancel: assert property (p_cancel) else $error("handshake did not cancel");
  property p_contact;
    (st_reg.motion == M_FORCE && run_ok && i_command_word == CMD_TO_OUTER && contact)
      |=> (o_drive_force_mode && o_current_limit == p_force && o_drive_speed == 16'h0000);
  endproperty
  a_contact: assert property (p_contact) else $error("contact not held");
  property p_force_phase;
    s_prepos_then_force |-> (o_drive_force_mode && o_drive_target == p_outer &&
                             $past(o_drive_target) == p_switch);
  endproperty
  a_force_phase: assert property (p_force_phase) else $error("bad pre-position");
  property p_open;
    (st_reg.motion == M_OPEN) |-> (!o_drive_force_mode && o_drive_target == p_inner);
  endproperty
  a_open: assert property (p_open) else $error("open not in position mode");
  property p_boot_report;
    $rose(st_reg.booted) |->
      (o_fault_code != FAULT_BOOTING && o_jaw_position_now == $past(i_jaw_position));
  endproperty
  a_boot_report: assert property (p_boot_report) else $error("no report after boot");
endmodule

// ---- testbench/grh_drive_model.sv ----
// Behavioural jaw drive that moves toward the commanded target
`timescale 1ns/1ps
module grh_drive_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Drive commands
  input wire logic i_drive_enable,
  input wire logic i_drive_force_mode,
  input wire logic [15:0] i_drive_target,
  input wire logic [15:0] i_part_at,
  // Feedback
  output logic [15:0] o_jaw_position,
  output logic [15:0] o_motor_current
);
  logic contact;
  assign contact = i_drive_force_mode && (o_jaw_position == i_part_at);
  // Contact with the part shows as a current rise above the threshold
  assign o_motor_current = contact ? 16'h0800 : 16'h0010;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_jaw_position <= 16'h0096;
    end else if (i_drive_enable && !contact) begin
      if (i_drive_target > o_jaw_position) begin
        o_jaw_position <= o_jaw_position + 16'h0001;
      end else if (i_drive_target < o_jaw_position) begin
        o_jaw_position <= o_jaw_position - 16'h0001;
      end
    end
  end
endmodule

// ---- testbench/test_gripper_command_handshake.sv ----
// Self-checking bench of the gripper command handshake block
`timescale 1ns/1ps
module test_gripper_command_handshake;
  import grh_pkg::*;
  logic clk = 1'b0, rst = 1'b1, boot = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] cmd = 16'h0000, pw = 16'h0000, cf = 16'h0000, ts = 16'h0000;
  logic [15:0] ot = 16'h0064, sp = 16'h008c, ep = 16'h0078, it = 16'h00c8;
  logic [7:0] prof = 8'h00, rcp = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [15:0] sw, fault, jaw_now, jaw, cur, tgt, spd, lim;
  logic en, fmode, dir, irq;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n, b1;
  initial begin
    forever #4 clk = ~clk;
  end
  grh_top dut_u (.i_ref_clk(clk), .i_reset(rst), .i_command_word(cmd),
    .i_profile_select(prof), .i_recipe_index(rcp), .i_part_window(pw), .i_clamp_force(cf),
    .i_travel_speed(ts), .i_outer_jaw_target(ot), .i_switchover_point(sp),
    .i_expected_part_position(ep), .i_inner_jaw_target(it), .o_state_word(sw),
    .o_fault_code(fault), .o_jaw_position_now(jaw_now), .i_boot_done(boot),
    .i_jaw_position(jaw), .i_motor_current(cur), .o_drive_enable(en),
    .o_drive_force_mode(fmode), .o_drive_dir(dir), .o_drive_target(tgt), .o_drive_speed(spd),
    .o_current_limit(lim), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
  grh_drive_model plant_u (.i_ref_clk(clk), .i_reset(rst), .i_drive_enable(en),
    .i_drive_force_mode(fmode), .i_drive_target(tgt), .i_part_at(ep),
    .o_jaw_position(jaw), .o_motor_current(cur));
  // ------------------------------------------------------------
  // Checking and reporting
  // ------------------------------------------------------------
  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] hs_bits(input logic ack, input logic pwr);
    return (16'h0040 | ({15'h0, ack} << SW_ACK) | ({15'h0, pwr} << SW_DRIVE_POWERED));
  endfunction
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Host tasks
  // ------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_sw(input int idx, input logic v);
    n = 0;
    while (sw[idx] !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic hs(input logic [7:0] p, input logic [7:0] r, input logic pwr);
    @(posedge clk);
    prof <= p;
    rcp <= r;
    cf <= 16'h0010 + 16'($urandom % 200);
    pw <= 16'($urandom % 4);
    ts <= 16'h0020 + 16'($urandom % 100);
    cmd <= CMD_TRANSFER;
    wait_sw(SW_ACK, 1'b1);
    cmp16("hs_set", hs_bits(1'b1, pwr), sw & 16'h1042);
    @(posedge clk);
    cmd <= CMD_IDLE;
    wait_sw(SW_ACK, 1'b0);
    cmp16("hs_clear", hs_bits(1'b0, pwr), sw & 16'h1042);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hdaa6b8eb));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp16("pre_boot_fault", FAULT_BOOTING, fault);
    cmp16("pre_boot_state", 16'h0000, sw);
    @(posedge clk);
    boot <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp16("link_active", 16'h0040, sw & 16'h0040);
    cmp16("boot_fault", FAULT_NONE, fault);
    cmp16("jaw_report", jaw, jaw_now);
    reg_rd(REG_CONTROL, rv);
    cmp32("ctrl_reset", CTRL_RESET, rv);
    reg_wr(REG_CONTROL, 32'h0400_0000);
    @(posedge clk);
    cmd <= CMD_TRANSFER;
    repeat (2) @(posedge clk);
    #1;
    cmp16("link_down", 16'h0000, sw & 16'h1040);
    @(posedge clk);
    cmd <= CMD_IDLE;
    reg_wr(REG_CONTROL, CTRL_RESET);
    reg_rd(4'h2, rv);
    cmp32("unmapped", 32'h0, rv);
    reg_wr(REG_IRQ_MASK, 32'h0000_000f);
    $display("test boot done");
    hs(PROF_MOTOR_ON, RECIPE_LIVE, 1'b1);
    cmp16("irq_level", 16'h0001, {15'h0, irq});
    reg_rd(REG_IRQ_STATUS, rv);
    cmp32("irq_ack", 32'h1, rv & 32'h1);
    reg_rd(REG_IRQ_STATUS, rv);
    cmp32("irq_cleared", 32'h0, rv);
    $display("test motor on done");
    hs(PROF_INSIDE_PREPOS, RECIPE_LIVE, 1'b1);
    b1 = $urandom % 16;
    @(posedge clk);
    cmd <= (16'h0001 << b1) | (16'h0001 << ((b1 + 1 + $urandom % 15) % 16));
    repeat (2) @(posedge clk);
    #1;
    cmp16("bad_cmd_fault", FAULT_BAD_CMD, fault);
    cmp16("bad_cmd_state", hs_bits(1'b0, 1'b1), sw & 16'h1042);
    cmp16("bad_cmd_motion", 16'h0000, {15'h0, en});
    @(posedge clk);
    cmd <= CMD_IDLE;
    repeat (2) @(posedge clk);
    #1;
    cmp16("fault_back", FAULT_NONE, fault);
    $display("test invalid command done");
    @(posedge clk);
    cmd <= CMD_TO_INNER;
    repeat (2) @(posedge clk);
    #1;
    cmp16("open_target", it, tgt);
    cmp16("open_mode", 16'h0000, {15'h0, fmode});
    cmp16("open_dir", 16'h0001, {15'h0, dir});
    wait_sw(SW_FLAGS_LSB + FL_INNER, 1'b1);
    cmp16("at_inner", 16'h0400, sw & 16'h0f00);
    @(posedge clk);
    cmd <= CMD_IDLE;
    @(posedge clk);
    cmd <= CMD_TO_OUTER;
    repeat (2) @(posedge clk);
    #1;
    cmp16("pre_target", sp, tgt);
    cmp16("pre_speed", ts, spd);
    n = 0;
    while (fmode !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp16("force_target", ot, tgt);
    n = 0;
    while (spd !== 16'h0000 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp16("hold_limit", cf, lim);
    reg_rd(REG_IRQ_STATUS, rv);
    cmp32("irq_contact", 32'h4, rv & 32'h4);
    @(posedge clk);
    cmd <= CMD_IDLE;
    $display("test grip done");
    hs(8'h52, RECIPE_LIVE, 1'b1);
    @(posedge clk);
    cmd <= CMD_TO_INNER;
    repeat (2) @(posedge clk);
    #1;
    cmp16("other_profile_idle", 16'h0000, {15'h0, en});
    $display("test other profile done");
    hs(PROF_MOTOR_OFF, RECIPE_LIVE, 1'b0);
    $display("test motor off done");
    final_report();
  end
endmodule
